// ---- core/tw_ctrl.sv ----
`timescale 1ns/1ps
module tw_ctrl #(
  parameter logic [7:0] DIV_DEFAULT = tw_pkg::DIV_RST
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [tw_pkg::AW-1:0] reg_addr,
  input wire logic [tw_pkg::DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [tw_pkg::DW-1:0] reg_rdata,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_n,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  output logic bus_irq
);
  import tw_pkg::*;

  typedef enum logic [3:0] {
    G_IDLE, G_START, G_HOLD, G_LOW, G_HIGH, G_STOPA, G_STOPB, G_RSA, G_RSB
  } tw_gen_t;

  // ************************************************************
  // Pin sampling and bus condition detection.
  // ************************************************************
  logic [1:0] pin_s;
  logic scl_s, sda_s, scl_p_q, sda_p_q;

  tw_sync #(.W(2)) u_sync (
    .mclk(mclk),
    .reset_n(reset_n),
    .d({scl_i, sda_i}),
    .q(pin_s)
  );

  assign scl_s = pin_s[1];
  assign sda_s = pin_s[0];

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  wire scl_rise = scl_s & ~scl_p_q;
  wire scl_fall = ~scl_s & scl_p_q;
  wire start_det = scl_s & scl_p_q & sda_p_q & ~sda_s;
  wire stop_det = scl_s & scl_p_q & ~sda_p_q & sda_s;

  // ************************************************************
  // Register state.
  // ************************************************************
  logic [DW-1:0] ctl_q, own_addr_q, div_q, rx_q, shift_q, cnt_q;
  logic [3:0] bit_q;
  logic repeat_start_request_q;
  logic byte_done_flag_q, slave_addressed_flag_q, bus_busy_flag_q;
  logic arbitration_lost_flag_q, slave_rw_flag_q;
  logic bus_interrupt_flag_q, received_ack_flag_q;
  logic in_q, adr_ph_q, sel_q, lost_q, eng_sda_q, hold_q;
  logic scl_lo_q, gen_sda_q;
  tw_gen_t st_q;

  wire enable = ctl_q[CTL_ENABLE];
  wire master_select = ctl_q[CTL_MASTER_SELECT];
  wire transmit_direction = ctl_q[CTL_TRANSMIT_DIRECTION];
  wire ack_disable = ctl_q[CTL_ACK_DISABLE];

  // ************************************************************
  // Register decode.
  // ************************************************************
  wire ctl_wr = reg_wr & (reg_addr == OFF_CTL);
  wire sts_wr = reg_wr & (reg_addr == OFF_STS);
  wire dat_wr = reg_wr & (reg_addr == OFF_DATA);
  wire adr_wr = reg_wr & (reg_addr == OFF_ADDR);
  wire div_wr = reg_wr & (reg_addr == OFF_DIV);
  wire dat_rd = reg_rd & (reg_addr == OFF_DATA);
  wire rel = (dat_wr & transmit_direction) | (dat_rd & ~transmit_direction);
  wire master_select_rise = ctl_wr & reg_wdata[CTL_MASTER_SELECT] & ~master_select;
  wire start_fail = master_select_rise & (bus_busy_flag_q | ~enable);
  wire repeat_start_request_req = ctl_wr & reg_wdata[CTL_REPEAT_START];
  wire repeat_start_request_fail = repeat_start_request_req & ~master_select;

  wire [DW-1:0] sts_word = {byte_done_flag_q, slave_addressed_flag_q,
    bus_busy_flag_q, arbitration_lost_flag_q, 1'b0, slave_rw_flag_q,
    bus_interrupt_flag_q, received_ack_flag_q};
  wire [DW-1:0] rd_mux =
    (reg_addr == OFF_CTL) ? ctl_q :
    (reg_addr == OFF_STS) ? sts_word :
    (reg_addr == OFF_DATA) ? rx_q :
    (reg_addr == OFF_ADDR) ? own_addr_q :
    (reg_addr == OFF_DIV) ? div_q : RD_ZERO;

  // ************************************************************
  // Engine decode.
  // ************************************************************
  wire gen_act = (st_q != G_IDLE);
  wire mst = gen_act & ~lost_q;
  wire sending = (mst & (adr_ph_q | transmit_direction)) |
    (sel_q & ~adr_ph_q & transmit_direction);
  wire match = (shift_q[7:1] == own_addr_q[7:1]);
  wire slv_match = adr_ph_q & ~mst & match & enable;
  wire ack_lo = adr_ph_q ? slv_match :
    (~sending & (mst | sel_q) & ~ack_disable);
  wire run = in_q & enable;
  wire arb_lost = run & scl_rise & (bit_q != ACK_BIT) & mst & sending &
    shift_q[7] & ~sda_s;
  wire ack_edge = run & scl_fall & (bit_q == LAST_DATA_BIT);
  wire byte_end = run & scl_fall & (bit_q == ACK_BIT);
  wire stop_unreq = stop_det & gen_act & (st_q != G_STOPB);
  wire master_select_clr = start_fail | arb_lost | stop_unreq;
  wire mal_set = start_fail | repeat_start_request_fail | arb_lost | stop_unreq;
  wire mif_set = byte_end | start_fail | repeat_start_request_fail | stop_unreq;

  // ************************************************************
  // Software registers.
  // ************************************************************
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ctl_q <= CTL_RST;
      own_addr_q <= ADDR_RST;
      div_q <= DIV_DEFAULT;
    end else begin
      if (ctl_wr) begin
        ctl_q <= reg_wdata & ~(8'h01 << CTL_REPEAT_START);
      end
      if (master_select_clr) begin
        ctl_q[CTL_MASTER_SELECT] <= 1'b0;
      end
      if (arb_lost) begin
        ctl_q[CTL_TRANSMIT_DIRECTION] <= 1'b0;
      end
      if (adr_wr) begin
        own_addr_q <= reg_wdata;
      end
      if (div_wr) begin
        div_q <= reg_wdata;
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= RD_ZERO;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : RD_ZERO;
    end
  end

  // ************************************************************
  // Status flags; a hardware set beats a clear in the same cycle.
  // ************************************************************
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      bus_interrupt_flag_q <= 1'b0;
      arbitration_lost_flag_q <= 1'b0;
      slave_addressed_flag_q <= 1'b0;
      byte_done_flag_q <= 1'b1;
      bus_busy_flag_q <= 1'b0;
      slave_rw_flag_q <= 1'b0;
      received_ack_flag_q <= 1'b1;
    end else begin
      bus_interrupt_flag_q <= mif_set | (bus_interrupt_flag_q &
        ~(sts_wr & ~reg_wdata[ST_BUS_INTERRUPT]));
      arbitration_lost_flag_q <= mal_set | (arbitration_lost_flag_q &
        ~(sts_wr & ~reg_wdata[ST_ARB_LOST]));
      slave_addressed_flag_q <= (ack_edge & slv_match) |
        (slave_addressed_flag_q & ~ctl_wr);
      byte_done_flag_q <= byte_end | (byte_done_flag_q & ~rel);
      bus_busy_flag_q <= start_det | (bus_busy_flag_q & ~stop_det);
      if (ack_edge & slv_match) begin
        slave_rw_flag_q <= shift_q[0];
      end
      if (run & scl_rise & (bit_q == ACK_BIT)) begin
        received_ack_flag_q <= sda_s;
      end
    end
  end

  // ************************************************************
  // Byte engine, shared by master and slave roles.
  // ************************************************************
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      in_q <= 1'b0;
      adr_ph_q <= 1'b0;
      sel_q <= 1'b0;
      lost_q <= 1'b0;
      eng_sda_q <= 1'b0;
      hold_q <= 1'b0;
      bit_q <= 4'h0;
      shift_q <= 8'h00;
      rx_q <= 8'h00;
    end else if (start_det | stop_det) begin
      in_q <= start_det & enable;
      adr_ph_q <= start_det;
      sel_q <= 1'b0;
      lost_q <= 1'b0;
      eng_sda_q <= 1'b0;
      hold_q <= 1'b0;
      // The SCL fall that closes a START is no data bit, so count from -1.
      bit_q <= start_det ? 4'hF : 4'h0;
    end else begin
      if (rel) begin
        hold_q <= 1'b0;
      end
      if (dat_wr & transmit_direction & (bit_q == 4'h0)) begin
        shift_q <= reg_wdata;
        eng_sda_q <= ~reg_wdata[7] & (mst | sel_q);
      end
      if (arb_lost) begin
        lost_q <= 1'b1;
        eng_sda_q <= 1'b0;
      end else if (run & scl_rise & (bit_q != ACK_BIT)) begin
        shift_q <= {shift_q[6:0], sda_s};
      end
      if (ack_edge) begin
        bit_q <= ACK_BIT;
        sel_q <= sel_q | slv_match;
        eng_sda_q <= ack_lo;
      end else if (byte_end) begin
        bit_q <= 4'h0;
        rx_q <= shift_q;
        adr_ph_q <= 1'b0;
        eng_sda_q <= 1'b0;
        lost_q <= 1'b0;
        hold_q <= sel_q & ~mst;
        in_q <= ~adr_ph_q | sel_q | mst;
      end else if (run & scl_fall) begin
        bit_q <= bit_q + 4'h1;
        eng_sda_q <= sending & ~shift_q[7];
      end
    end
  end

  // ************************************************************
  // Master clock generator.
  // ************************************************************
  wire cnt_en = gen_act & ~((st_q == G_HIGH) & ~scl_s);
  wire tick = cnt_en & (cnt_q == div_q);

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= (tick | ~cnt_en) ? 8'h00 : cnt_q + 8'h01;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      repeat_start_request_q <= 1'b0;
    end else begin
      repeat_start_request_q <= (repeat_start_request_req & master_select) |
        (repeat_start_request_q & master_select & (st_q != G_RSA));
    end
  end

  // Clock stretching by a slave holds the count at zero in the high phase.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= G_IDLE;
      scl_lo_q <= 1'b0;
      gen_sda_q <= 1'b0;
    end else if (~enable | stop_unreq | (byte_end & lost_q)) begin
      st_q <= G_IDLE;
      scl_lo_q <= 1'b0;
      gen_sda_q <= 1'b0;
    end else if (byte_end & gen_act) begin
      st_q <= G_HOLD;
      scl_lo_q <= 1'b1;
    end else begin
      unique case (st_q)
        G_IDLE: begin
          if (master_select_rise & ~start_fail) begin
            st_q <= G_START;
            gen_sda_q <= 1'b1;
          end
        end
        G_START: begin
          if (tick) begin
            scl_lo_q <= 1'b1;
            st_q <= G_HOLD;
          end
        end
        G_HOLD: begin
          if (~master_select) begin
            st_q <= G_STOPA;
            gen_sda_q <= 1'b1;
          end else if (repeat_start_request_q) begin
            st_q <= G_RSA;
            gen_sda_q <= 1'b0;
          end else if (rel) begin
            st_q <= G_LOW;
            gen_sda_q <= 1'b0;
          end
        end
        G_LOW: begin
          if (tick) begin
            scl_lo_q <= 1'b0;
            st_q <= G_HIGH;
          end
        end
        G_HIGH: begin
          if (tick) begin
            scl_lo_q <= 1'b1;
            st_q <= G_LOW;
          end
        end
        G_STOPA: begin
          if (tick) begin
            scl_lo_q <= 1'b0;
            st_q <= G_STOPB;
          end
        end
        G_STOPB: begin
          if (tick) begin
            gen_sda_q <= 1'b0;
            st_q <= G_IDLE;
          end
        end
        G_RSA: begin
          if (tick) begin
            scl_lo_q <= 1'b0;
            st_q <= G_RSB;
          end
        end
        G_RSB: begin
          if (tick) begin
            gen_sda_q <= 1'b1;
            st_q <= G_START;
          end
        end
      endcase
    end
  end

  // ************************************************************
  // Open-drain pins and interrupt request.
  // ************************************************************
  // Pins only ever pull low, so a lost master can never fight the bus.
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe_n = ~(scl_lo_q | hold_q);
  assign sda_oe_n = ~(gen_sda_q | eng_sda_q);
  assign bus_irq = bus_interrupt_flag_q & ctl_q[CTL_INTERRUPT_ENABLE];

endmodule

// ---- core/tw_pkg.sv ----
package tw_pkg;

  // ************************************************************
  // Register map.
  // ************************************************************
  localparam int AW = 3;
  localparam int DW = 8;
  localparam logic [AW-1:0] OFF_CTL = 3'h0;
  localparam logic [AW-1:0] OFF_STS = 3'h1;
  localparam logic [AW-1:0] OFF_DATA = 3'h2;
  localparam logic [AW-1:0] OFF_ADDR = 3'h3;
  localparam logic [AW-1:0] OFF_DIV = 3'h4;

  // ************************************************************
  // Control register fields.
  // ************************************************************
  localparam int CTL_ENABLE = 7;
  localparam int CTL_INTERRUPT_ENABLE = 6;
  localparam int CTL_MASTER_SELECT = 5;
  localparam int CTL_TRANSMIT_DIRECTION = 4;
  localparam int CTL_ACK_DISABLE = 3;
  localparam int CTL_REPEAT_START = 2;

  // ************************************************************
  // Status register fields.
  // ************************************************************
  localparam int ST_BYTE_DONE = 7;
  localparam int ST_SLAVE_ADDRESSED = 6;
  localparam int ST_BUS_BUSY = 5;
  localparam int ST_ARB_LOST = 4;
  localparam int ST_SLAVE_RW = 2;
  localparam int ST_BUS_INTERRUPT = 1;
  localparam int ST_RECEIVED_ACK = 0;

  // ************************************************************
  // Reset values and bit counts.
  // ************************************************************
  localparam logic [DW-1:0] CTL_RST = 8'h00;
  localparam logic [DW-1:0] ADDR_RST = 8'h00;
  localparam logic [DW-1:0] DIV_RST = 8'h0F;
  localparam logic [DW-1:0] RD_ZERO = 8'h00;
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;
  localparam logic [3:0] ACK_BIT = 4'h8;

endpackage

// ---- core/tw_sync.sv ----
`timescale 1ns/1ps
module tw_sync #(
  parameter int W = 2
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_q;

  // The first stage feeds the second stage only.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      meta_q <= '1;
      q <= '1;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule

// ---- tb/tw_ctrl_assertions.sv ----
`timescale 1ns/1ps
module tw_ctrl_assertions (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [tw_pkg::AW-1:0] reg_addr,
  input wire logic [tw_pkg::DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [tw_pkg::DW-1:0] reg_rdata,
  input wire logic scl_i,
  input wire logic scl_o,
  input wire logic scl_oe_n,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_n,
  input wire logic bus_irq
);
  import tw_pkg::*;
  // ****
  // Last control write, as software meant it.
  // ****
  logic mst_q;
  logic ien_q;
  wire ctl_wr = reg_wr && reg_addr == OFF_CTL;
  wire dat_wr = reg_wr && reg_addr == OFF_DATA;
  wire dat_rd = reg_rd && reg_addr == OFF_DATA;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      mst_q <= 1'b0;
      ien_q <= 1'b0;
    end else if (ctl_wr) begin
      mst_q <= reg_wdata[CTL_MASTER_SELECT];
      ien_q <= reg_wdata[CTL_INTERRUPT_ENABLE];
    end
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);
  a_rdata_one_cycle: assert property (!reg_rd |=> reg_rdata == RD_ZERO)
    else $error("read data outside its cycle");
  a_pins_pull_only: assert property (!scl_o && !sda_o)
    else $error("pin driven high");
  a_restart_reads_zero: assert property (
    reg_rd && reg_addr == OFF_CTL |=> !reg_rdata[CTL_REPEAT_START])
    else $error("restart bit read back set");
  a_ctl_clears_addr: assert property (
    ctl_wr ##2 (reg_rd && reg_addr == OFF_STS)
    |=> !reg_rdata[ST_SLAVE_ADDRESSED])
    else $error("addressed flag survived control write");
  a_irq_needs_enable: assert property (bus_irq |-> ien_q)
    else $error("interrupt without enable");
  a_stop_after_clear: assert property (
    ctl_wr && !reg_wdata[CTL_MASTER_SELECT] && mst_q && !scl_oe_n
    |-> ##[1:40] (scl_oe_n && !sda_oe_n) ##[1:40] sda_oe_n)
    else $error("no stop after master clear");
  a_data_starts_byte: assert property (
    dat_wr && mst_q && !scl_oe_n |-> ##[1:20] scl_oe_n)
    else $error("data write did not start byte");
  a_read_frees_scl: assert property (
    dat_rd && !mst_q && !scl_oe_n |-> ##[1:5] scl_oe_n)
    else $error("data read did not free clock");
  c_stop: cover property (ctl_wr && mst_q && !reg_wdata[CTL_MASTER_SELECT]);
  c_irq: cover property ($rose(bus_irq));
  c_release: cover property (dat_rd && !scl_oe_n);
endmodule

// ---- tb/tw_bus_model.sv ----
`timescale 1ns/1ps
module tw_bus_model (
  input wire logic scl,
  input wire logic sda,
  output logic scl_pull_n,
  output logic sda_pull_n
);
  // ****
  // Far side: an acknowledging slave and an 800 ns master.
  // ****
  // Released lines float to the pull-up, so a release reads one unless the other side still pulls low.
  logic ack_on = 1'b0;
  logic ack_seen = 1'b1;
  logic stop_seen = 1'b0;
  logic [7:0] got = 8'h00;
  int nbit = 0;
  initial begin
    scl_pull_n = 1'b1;
    sda_pull_n = 1'b1;
  end
  always @(negedge sda) begin
    if (scl) begin
      nbit = -1;
    end
  end
  always @(posedge sda) begin
    if (scl) begin
      stop_seen = 1'b1;
    end
  end
  always @(posedge scl) begin
    if (nbit >= 0 && nbit < 8) begin
      got = {got[6:0], sda};
    end
    ack_seen = sda;
  end
  always @(negedge scl) begin
    nbit = nbit + 1;
    if (nbit == 8 && ack_on) begin
      sda_pull_n = 1'b0;
    end
    if (nbit == 9) begin
      nbit = 0;
      if (ack_on) begin
        sda_pull_n = 1'b1;
      end
    end
  end
  // The wait honours a slave that holds the clock low.
  task automatic pulse();
    #400 scl_pull_n = 1'b1;
    wait (scl === 1'b1);
    #400 scl_pull_n = 1'b0;
  endtask
  task automatic start();
    sda_pull_n = 1'b0;
    #400 scl_pull_n = 1'b0;
  endtask
  task automatic send(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      sda_pull_n = b[i];
      pulse();
    end
    sda_pull_n = 1'b1;
    pulse();
  endtask
  task automatic stop();
    sda_pull_n = 1'b0;
    #400 scl_pull_n = 1'b1;
    wait (scl === 1'b1);
    #400 sda_pull_n = 1'b1;
  endtask
endmodule

// ---- tb/tw_ctrl_tb_top.sv ----
`timescale 1ns/1ps
module tw_ctrl_tb_top;
  import tw_pkg::*;
  localparam logic [7:0] DIV_INIT = 8'h0F;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic [AW-1:0] reg_addr = 3'h0;
  logic [DW-1:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [DW-1:0] reg_rdata;
  logic scl_o, scl_oe_n, sda_o, sda_oe_n, bus_irq, m_scl_n, m_sda_n;
  logic [7:0] v;
  int err_total = 0;
  int tests_run = 0;
  wire scl = scl_oe_n & m_scl_n;
  wire sda = sda_oe_n & m_sda_n;
  tw_ctrl #(.DIV_DEFAULT(DIV_INIT)) u_dut (.mclk, .reset_n, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .scl_i(scl), .scl_o,
    .scl_oe_n, .sda_i(sda), .sda_o, .sda_oe_n, .bus_irq);
  tw_bus_model u_bus (.scl(scl), .sda(sda), .scl_pull_n(m_scl_n),
    .sda_pull_n(m_sda_n));
  // ****
  // Shared bus cycles and comparison.
  // ****
  initial begin
    forever #50 mclk = ~mclk;
  end
  task automatic chk(input string n, input logic [7:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic wr(input logic [AW-1:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [AW-1:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
    @(posedge mclk);
  endtask
  task automatic wait_irq();
    for (int i = 0; i < 500 && bus_irq !== 1'b1; i++)
      @(posedge mclk);
    chk("bus_irq", 8'(bus_irq), 8'h01);
  endtask
  task automatic poll_idle();
    v = 8'hFF;
    for (int i = 0; i < 10 && v[ST_BUS_BUSY] !== 1'b0; i++)
      rd(OFF_STS);
    chk("idle", 8'(v[ST_BUS_BUSY]), 8'h00);
  endtask
  task automatic t_reset();
    rd(OFF_STS);
    chk("status", v, 8'h81);
    rd(OFF_CTL);
    chk("control", v, CTL_RST);
    rd(OFF_DIV);
    chk("divider", v, DIV_INIT);
    rd(3'h5);
    chk("unmapped", v, RD_ZERO);
    wr(OFF_DIV, 8'h04);
  endtask
  task automatic t_master();
    u_bus.ack_on = 1'b1;
    wr(OFF_CTL, 8'h80);
    wr(OFF_CTL, 8'hF0);
    for (int i = 0; i < 100 && scl_oe_n !== 1'b0; i++)
      @(posedge mclk);
    rd(OFF_STS);
    chk("busy", 8'(v[ST_BUS_BUSY]), 8'h01);
    wr(OFF_DATA, 8'hA0);
    wait_irq();
    chk("sent", u_bus.got, 8'hA0);
    rd(OFF_STS);
    chk("ack", 8'(v[ST_RECEIVED_ACK]), 8'h00);
    wr(OFF_CTL, 8'hD0);
    rd(OFF_DATA);
    chk("last byte", v, 8'hA0);
    poll_idle();
    chk("stop", 8'(u_bus.stop_seen), 8'h01);
    wr(OFF_STS, 8'h00);
    chk("irq clear", 8'(bus_irq), 8'h00);
    u_bus.ack_on = 1'b0;
  endtask
  task automatic t_slave();
    u_bus.start();
    @(posedge mclk);
    wr(OFF_CTL, 8'hF0);
    rd(OFF_CTL);
    chk("refused", 8'(v[CTL_MASTER_SELECT]), 8'h00);
    rd(OFF_STS);
    chk("arb lost", 8'(v[ST_ARB_LOST]), 8'h01);
    chk("arb irq", 8'(bus_irq), 8'h01);
    chk("no stop", 8'(sda_oe_n), 8'h01);
    wr(OFF_STS, 8'h00);
    wr(OFF_ADDR, 8'hA8);
    wr(OFF_CTL, 8'hC0);
    u_bus.send(8'hA8);
    @(posedge mclk);
    wait_irq();
    chk("addr ack", 8'(u_bus.ack_seen), 8'h00);
    rd(OFF_STS);
    chk("addressed", 8'(v[ST_SLAVE_ADDRESSED]), 8'h01);
    chk("rw", 8'(v[ST_SLAVE_RW]), 8'h00);
    wr(OFF_CTL, 8'hC0);
    rd(OFF_STS);
    chk("addr clear", 8'(v[ST_SLAVE_ADDRESSED]), 8'h00);
    wr(OFF_STS, 8'h00);
    chk("scl held", 8'(scl_oe_n), 8'h00);
    rd(OFF_DATA);
    for (int i = 0; i < 10 && scl_oe_n !== 1'b1; i++)
      @(posedge mclk);
    chk("scl free", 8'(scl_oe_n), 8'h01);
    u_bus.send(8'h3C);
    @(posedge mclk);
    wait_irq();
    rd(OFF_STS);
    chk("data irq", 8'(v[ST_SLAVE_ADDRESSED]), 8'h00);
    rd(OFF_DATA);
    chk("rx byte", v, 8'h3C);
    u_bus.stop();
    @(posedge mclk);
    poll_idle();
  endtask
  task automatic stop_test();
    $display("Checks made %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (4) @(posedge mclk);
    t_reset();
    t_master();
    t_slave();
    stop_test();
  end
  // The whole run needs several hundred cycles; this allows 20000 of them.
  initial begin
    #2000000;
    err_total++;
    stop_test();
  end
endmodule
bind tw_ctrl tw_ctrl_assertions u_chk (.mclk, .reset_n, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .scl_i, .scl_o, .scl_oe_n,
  .sda_i, .sda_o, .sda_oe_n, .bus_irq);
